// ### inc/branch_trace_pkg.sv
// branch trace recorder constants: register offsets, control bit positions,
// reset values and the memory logging state encoding.
// assumes a 32-bit apb slave with byte addresses and 32-bit linear addresses.
package branch_trace_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_DEBUG_CTL   = 8'h00;
	localparam logic [7:0] OFS_FEATURE_ID  = 8'h04;
	localparam logic [7:0] OFS_MISC_FEAT   = 8'h08;
	localparam logic [7:0] OFS_AREA_PTR    = 8'h0C;
	localparam logic [7:0] OFS_STACK_TOP   = 8'h10;
	localparam logic [7:0] OFS_LER_SOURCE  = 8'h14;
	localparam logic [7:0] OFS_LER_TARGET  = 8'h18;
	localparam logic [7:0] OFS_STACK_BASE  = 8'h20;
	localparam logic [7:0] OFS_STACK_LAST  = 8'h3C;
	localparam logic [7:0] OFS_BUF_BASE    = 8'h40;
	localparam logic [7:0] OFS_BUF_INDEX   = 8'h44;
	localparam logic [7:0] OFS_BUF_MAX     = 8'h48;
	localparam logic [7:0] OFS_BUF_THRESH  = 8'h4C;

	// debug control bit positions
	localparam int CTL_W            = 5;
	localparam int CTL_RECORD_EN    = 0;
	localparam int CTL_STEP_BRANCH  = 1;
	localparam int CTL_MSG_EN       = 2;
	localparam int CTL_MEM_LOG_EN   = 3;
	localparam int CTL_FULL_IRQ_EN  = 4;

	// status bit positions
	localparam int FEATURE_DS_BIT   = 21;
	localparam int TRACE_ABSENT_BIT = 11;

	// reset values
	localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
	localparam logic [31:0]      REG_RESET = 32'h0000_0000;
	localparam logic [63:0]      REC_RESET = 64'h0000_0000_0000_0000;
	localparam logic [1:0]       TOS_RESET = 2'h0;

	// memory record geometry and descriptor layout behind the area pointer
	localparam logic [31:0] REC_BYTES      = 32'h0000_0008;
	localparam logic [31:0] DESC_INDEX_OFS = 32'h0000_0004;

	// memory logging states
	typedef enum logic [1:0] {
		LOG_IDLE = 2'b00,
		LOG_REC  = 2'b01,
		LOG_IDX  = 2'b11
	} log_state_type;

endpackage

// ### logic/record_sorter.sv
// record_sorter: orders the records of one control transfer.
// assumes the core reports a taken branch and an interrupt or exception
// of the same transfer in one cycle.
`timescale 1ns/1ps
`default_nettype none
module record_sorter (
	input  wire logic        branch_valid,
	input  wire logic [31:0] branch_from,
	input  wire logic [31:0] branch_to,
	input  wire logic        excint_valid,
	input  wire logic        excint_fault,
	input  wire logic [31:0] excint_from,
	input  wire logic [31:0] excint_to,
	output logic      [1:0]  rec_cnt,
	output logic      [63:0] rec_first,
	output logic      [63:0] rec_second,
	output logic             branch_kept
);
	// a fault drops the branch record, a trap or interrupt keeps it first
	always_comb begin
		branch_kept = branch_valid && !(excint_valid && excint_fault);
		rec_first   = {excint_to, excint_from};
		rec_second  = {excint_to, excint_from};
		rec_cnt     = 2'd0;
		if (branch_kept && excint_valid) begin
			rec_first = {branch_to, branch_from};
			rec_cnt   = 2'd2;
		end else if (branch_kept) begin
			rec_first = {branch_to, branch_from};
			rec_cnt   = 2'd1;
		end else if (excint_valid) begin
			rec_cnt = 2'd1;
		end
	end
endmodule
`default_nettype wire

// ### logic/branch_stack.sv
// branch_stack: four-entry circular record stack with top pointer.
// assumes at most two records pushed per cycle, in order.
`timescale 1ns/1ps
`default_nettype none
module branch_stack
	import branch_trace_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [1:0]  push_cnt,
	input  wire logic [63:0] push_first,
	input  wire logic [63:0] push_second,
	input  wire logic [1:0]  rd_idx,
	output logic      [1:0]  top_ptr,
	output logic      [63:0] top_rec,
	output logic      [63:0] rd_rec
);
	typedef struct packed {
		logic [3:0][63:0] ent;
		logic [1:0]       tos;
	} stack_state_type;

	stack_state_type r;
	stack_state_type n;

	// pointer moves before each store and wraps from 3 to 0
	always_comb begin
		n = r;
		if (push_cnt != 2'd0) begin
			n.tos        = r.tos + 2'd1;
			n.ent[n.tos] = push_first;
		end
		if (push_cnt == 2'd2) begin
			n.tos        = r.tos + 2'd2;
			n.ent[n.tos] = push_second;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			r.ent <= {4{REC_RESET}};
			r.tos <= TOS_RESET;
		end else begin
			r <= n;
		end
	end

	assign top_ptr = r.tos;
	assign top_rec = r.ent[r.tos];
	assign rd_rec  = r.ent[rd_idx];
endmodule
`default_nettype wire

// ### logic/branch_trace_recorder.sv
// branch_trace_recorder: branch stack, last exception record, control-flow
// stepping, bus trace messages and memory trace logging behind an apb slave.
// assumes core transfer reports and memory handshake are on sys_clk.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module branch_trace_recorder
	import branch_trace_pkg::*;
#(
	parameter bit DEBUG_STORE_PRESENT = 1'b1
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xfer_valid,
	input  wire logic        xfer_branch,
	input  wire logic [31:0] branch_from,
	input  wire logic [31:0] branch_to,
	input  wire logic        xfer_excint,
	input  wire logic        excint_fault,
	input  wire logic [31:0] excint_from,
	input  wire logic [31:0] excint_to,
	output logic             xfer_ready,
	input  wire logic        debug_exc,
	input  wire logic        trap_single_step,
	output logic             step_exc_req,
	output logic             trap_step_clear,
	output logic             msg_valid,
	output logic      [31:0] msg_source,
	output logic      [31:0] msg_target,
	output logic             mem_valid,
	output logic      [31:0] mem_addr,
	output logic      [63:0] mem_data,
	input  wire logic        mem_ready,
	output logic             log_full_irq
);
	typedef struct packed {
		logic [CTL_W-1:0] ctl;
		logic [31:0]      area_ptr;
		logic [31:0]      ler_src;
		logic [31:0]      ler_tgt;
		logic [31:0]      buf_base;
		logic [31:0]      buf_idx;
		logic [31:0]      buf_max;
		logic [31:0]      buf_thr;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             core_ready;
		logic             pend;
		logic [63:0]      pend_rec;
		logic             msg_valid;
		logic [63:0]      msg_rec;
		log_state_type    lst;
		logic             mem_valid;
		logic [31:0]      mem_addr;
		logic [63:0]      mem_data;
		logic             irq;
		logic             step_req;
		logic             tf_clear;
	} rec_state_type;

	localparam logic TRACE_ABSENT = !DEBUG_STORE_PRESENT;

	rec_state_type r;
	rec_state_type n;

	logic [1:0]  rec_cnt;
	logic [63:0] rec_first;
	logic [63:0] rec_second;
	logic        branch_kept;
	logic [1:0]  top_ptr;
	logic [63:0] top_rec;
	logic [63:0] rd_rec;
	logic [1:0]  push_cnt;
	logic        accept;
	logic        apb_done;
	logic        apb_wr;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic        emit_now;
	logic [63:0] emit_rec;
	logic [31:0] idx_step;
	logic [31:0] idx_next;
	logic        dbg_now;

	record_sorter u_sorter (
		.branch_valid (xfer_valid && xfer_branch),
		.branch_from  (branch_from),
		.branch_to    (branch_to),
		.excint_valid (xfer_valid && xfer_excint),
		.excint_fault (excint_fault),
		.excint_from  (excint_from),
		.excint_to    (excint_to),
		.rec_cnt      (rec_cnt),
		.rec_first    (rec_first),
		.rec_second   (rec_second),
		.branch_kept  (branch_kept)
	);

	branch_stack u_stack (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.push_cnt    (push_cnt),
		.push_first  (rec_first),
		.push_second (rec_second),
		.rd_idx      (paddr[4:3]),
		.top_ptr     (top_ptr),
		.top_rec     (top_rec),
		.rd_rec      (rd_rec)
	);

	// transfer acceptance and stack push
	assign accept   = xfer_valid && r.core_ready && (rec_cnt != 2'd0);
	assign push_cnt = (accept && r.ctl[CTL_RECORD_EN]) ? rec_cnt : 2'd0;

	// apb access completes on the second access cycle; a write lands at that same edge
	assign apb_done = psel && penable && r.pready;
	assign apb_wr   = apb_done && pwrite;

	// register read mux
	always_comb begin
		rd_val = REG_RESET;
		rd_hit = 1'b1;
		if (paddr >= OFS_STACK_BASE && paddr <= OFS_STACK_LAST && paddr[1:0] == 2'b00) begin
			rd_val = paddr[2] ? rd_rec[63:32] : rd_rec[31:0];
		end else begin
			unique case (paddr)
				OFS_DEBUG_CTL:  rd_val = {27'h0, r.ctl};
				OFS_FEATURE_ID: rd_val[FEATURE_DS_BIT] = DEBUG_STORE_PRESENT;
				OFS_MISC_FEAT:  rd_val[TRACE_ABSENT_BIT] = TRACE_ABSENT;
				OFS_AREA_PTR:   rd_val = r.area_ptr;
				OFS_STACK_TOP:  rd_val = {30'h0, top_ptr};
				OFS_LER_SOURCE: rd_val = r.ler_src;
				OFS_LER_TARGET: rd_val = r.ler_tgt;
				OFS_BUF_BASE:   rd_val = r.buf_base;
				OFS_BUF_INDEX:  rd_val = r.buf_idx;
				OFS_BUF_MAX:    rd_val = r.buf_max;
				OFS_BUF_THRESH: rd_val = r.buf_thr;
				default:        rd_hit = 1'b0;
			endcase
		end
	end

	// next index with circular wrap when the full interrupt is off
	always_comb begin
		idx_step = r.buf_idx + REC_BYTES;
		idx_next = idx_step;
		if (idx_step >= r.buf_max && !r.ctl[CTL_FULL_IRQ_EN]) begin
			idx_next = r.buf_base;
		end
	end

	// record chosen for the trace path this cycle
	always_comb begin
		emit_now = 1'b0;
		emit_rec = rec_first;
		if (r.ctl[CTL_MSG_EN]) begin
			if (r.pend) begin
				emit_now = (r.lst == LOG_IDLE);
				emit_rec = r.pend_rec;
			end else if (accept) begin
				emit_now = 1'b1;
			end
		end
	end

	assign dbg_now = debug_exc || (accept && r.ctl[CTL_STEP_BRANCH] && trap_single_step);

	// main next-state logic
	always_comb begin
		n = r;
		n.pready    = 1'b0;
		n.pslverr   = 1'b0;
		n.msg_valid = 1'b0;
		n.irq       = 1'b0;
		n.step_req  = 1'b0;
		n.tf_clear  = 1'b0;

		// apb slave: answer one cycle into the access phase
		if (psel && penable && !r.pready) begin
			n.pready  = 1'b1;
			n.pslverr = !rd_hit;
			n.prdata  = pwrite ? REG_RESET : rd_val;
		end
		if (apb_wr && rd_hit) begin
			unique case (paddr)
				OFS_DEBUG_CTL: begin
					n.ctl = pwdata[CTL_W-1:0];
					if (TRACE_ABSENT) begin
						n.ctl[CTL_MEM_LOG_EN]  = 1'b0;
						n.ctl[CTL_FULL_IRQ_EN] = 1'b0;
					end
				end
				OFS_AREA_PTR:   n.area_ptr = DEBUG_STORE_PRESENT ? pwdata : REG_RESET;
				OFS_BUF_BASE:   n.buf_base = pwdata;
				OFS_BUF_INDEX:  n.buf_idx  = pwdata;
				OFS_BUF_MAX:    n.buf_max  = pwdata;
				OFS_BUF_THRESH: n.buf_thr  = pwdata;
				default:        n.ctl = r.ctl;
			endcase
		end

		// last branch before an exception or interrupt
		if (accept && xfer_excint && r.ctl[CTL_RECORD_EN]) begin
			if (branch_kept) begin
				n.ler_src = branch_from;
				n.ler_tgt = branch_to;
			end else begin
				n.ler_src = top_rec[31:0];
				n.ler_tgt = top_rec[63:32];
			end
		end

		// trace path: second record of a pair waits one turn
		if (r.pend && emit_now) begin
			n.pend = 1'b0;
		end
		if (accept && r.ctl[CTL_MSG_EN] && rec_cnt == 2'd2) begin
			n.pend     = 1'b1;
			n.pend_rec = rec_second;
		end
		if (emit_now && !r.ctl[CTL_MEM_LOG_EN]) begin
			n.msg_valid = 1'b1;
			n.msg_rec   = emit_rec;
		end

		// memory logging: record write, then index write-back
		unique case (r.lst)
			LOG_IDLE: begin
				if (emit_now && r.ctl[CTL_MEM_LOG_EN]) begin
					if (!(r.ctl[CTL_FULL_IRQ_EN] && r.buf_idx >= r.buf_max)) begin
						n.lst       = LOG_REC;
						n.mem_valid = 1'b1;
						n.mem_addr  = r.buf_base + r.buf_idx;
						n.mem_data  = emit_rec;
					end
				end
			end
			LOG_REC: begin
				if (mem_ready) begin
					n.lst      = LOG_IDX;
					n.buf_idx  = idx_next;
					n.mem_addr = r.area_ptr + DESC_INDEX_OFS;
					n.mem_data = {REG_RESET, idx_next};
					if (r.ctl[CTL_FULL_IRQ_EN] && r.buf_idx < r.buf_thr && idx_step >= r.buf_thr) begin
						n.irq = 1'b1;
					end
				end
			end
			LOG_IDX: begin
				if (mem_ready) begin
					n.lst       = LOG_IDLE;
					n.mem_valid = 1'b0;
				end
			end
			default: begin
				n.lst       = LOG_IDLE;
				n.mem_valid = 1'b0;
			end
		endcase

		// debug exception: stop recording, end control-flow stepping
		if (accept && r.ctl[CTL_STEP_BRANCH] && trap_single_step) begin
			n.step_req = 1'b1;
		end
		if (dbg_now) begin
			n.ctl[CTL_RECORD_EN] = 1'b0;
			if (r.ctl[CTL_STEP_BRANCH]) begin
				n.ctl[CTL_STEP_BRANCH] = 1'b0;
				n.tf_clear             = 1'b1;
			end
		end

		// ready to the core only when no record waits and memory is idle
		n.core_ready = !n.pend && (n.lst == LOG_IDLE);
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			r.ctl        <= CTL_RESET;
			r.area_ptr   <= REG_RESET;
			r.ler_src    <= REG_RESET;
			r.ler_tgt    <= REG_RESET;
			r.buf_base   <= REG_RESET;
			r.buf_idx    <= REG_RESET;
			r.buf_max    <= REG_RESET;
			r.buf_thr    <= REG_RESET;
			r.prdata     <= REG_RESET;
			r.pready     <= 1'b0;
			r.pslverr    <= 1'b0;
			r.core_ready <= 1'b1;
			r.pend       <= 1'b0;
			r.pend_rec   <= REC_RESET;
			r.msg_valid  <= 1'b0;
			r.msg_rec    <= REC_RESET;
			r.lst        <= LOG_IDLE;
			r.mem_valid  <= 1'b0;
			r.mem_addr   <= REG_RESET;
			r.mem_data   <= REC_RESET;
			r.irq        <= 1'b0;
			r.step_req   <= 1'b0;
			r.tf_clear   <= 1'b0;
		end else begin
			r <= n;
		end
	end

	// outputs straight from state flops
	assign prdata          = r.prdata;
	assign pready          = r.pready;
	assign pslverr         = r.pslverr;
	assign xfer_ready      = r.core_ready;
	assign step_exc_req    = r.step_req;
	assign trap_step_clear = r.tf_clear;
	assign msg_valid       = r.msg_valid;
	assign msg_source      = r.msg_rec[31:0];
	assign msg_target      = r.msg_rec[63:32];
	assign mem_valid       = r.mem_valid;
	assign mem_addr        = r.mem_addr;
	assign mem_data        = r.mem_data;
	assign log_full_irq    = r.irq;
endmodule
`default_nettype wire

// ### testbench/btr_mem_model.sv
// memory model: takes record and index writes from the trace logger
// assumes one write in flight; slow adds three wait cycles per write
`timescale 1ns/1ps
`default_nettype none
module btr_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	input  wire logic [63:0] mem_data,
	input  wire logic        slow,
	output logic             mem_ready
);
	logic [63:0] words [logic [31:0]];
	int          wait_cnt;
	// answer after the chosen delay; store at the edge that samples ready
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mem_ready <= 1'b0;
			wait_cnt <= 0;
		end else if (mem_valid && mem_ready) begin
			words[mem_addr] = mem_data;
			mem_ready <= 1'b0;
		end else if (mem_valid && wait_cnt >= (slow ? 3 : 0)) begin
			mem_ready <= 1'b1;
			wait_cnt <= 0;
		end else if (mem_valid) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ### testbench/branch_trace_recorder_asserts.sv
// checker on the ports of branch_trace_recorder
// assumes it is bound to the design by the statement at the foot
`timescale 1ns/1ps
`default_nettype none
module branch_trace_recorder_asserts (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        xfer_valid,
	input wire logic        xfer_ready,
	input wire logic        step_exc_req,
	input wire logic        trap_step_clear,
	input wire logic        msg_valid,
	input wire logic        mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_data,
	input wire logic        mem_ready,
	input wire logic        log_full_irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("register access not answered");
	step_cause_a: assert property (step_exc_req |-> $past(xfer_valid && xfer_ready))
		else $error("step exception without a transfer");
	step_pulse_a: assert property (step_exc_req |=> !step_exc_req)
		else $error("step exception longer than one cycle");
	step_clear_a: assert property (step_exc_req |-> trap_step_clear)
		else $error("trap flag not cleared with step");
	irq_pulse_a: assert property (log_full_irq |=> !log_full_irq)
		else $error("near full event longer than one cycle");
	irq_write_a: assert property (log_full_irq |-> mem_valid)
		else $error("near full event outside index write");
	mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
		else $error("memory request changed before ready");
	one_dest_a: assert property (msg_valid |-> !mem_valid)
		else $error("record sent to bus and memory");
	msg_pair_a: assert property (msg_valid && !xfer_ready |=> msg_valid)
		else $error("second message of a pair missing");
	ready_back_a: assert property ($fell(xfer_ready) |-> ##[1:40] xfer_ready)
		else $error("transfer port stuck busy");
endmodule
bind branch_trace_recorder branch_trace_recorder_asserts chk_i (.sys_clk, .rstn, .psel, .penable, .pready,
	.xfer_valid, .xfer_ready, .step_exc_req, .trap_step_clear, .msg_valid, .mem_valid, .mem_addr, .mem_data,
	.mem_ready, .log_full_irq);
`default_nettype wire

// ### testbench/branch_trace_recorder_bench.sv
// self-checking bench for branch_trace_recorder
// assumes btr_mem_model as memory and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module branch_trace_recorder_bench;
	import branch_trace_pkg::*;
	logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, e, slow;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, branch_from, branch_to, excint_from, excint_to;
	logic [31:0] msg_source, msg_target, mem_addr;
	logic        xfer_valid, xfer_branch, xfer_excint, excint_fault, xfer_ready, mem_valid, mem_ready;
	logic        debug_exc, trap_single_step, step_exc_req, trap_step_clear, msg_valid, log_full_irq;
	logic [63:0] mem_data, rec;
	logic [63:0] msgq[$];
	int          error_cnt, n_compared, n_step, n_clr, n_irq;
	branch_trace_recorder #(.DEBUG_STORE_PRESENT(1'b1)) uut (.sys_clk, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_valid, .xfer_branch, .branch_from, .branch_to,
		.xfer_excint, .excint_fault, .excint_from, .excint_to, .xfer_ready, .debug_exc, .trap_single_step,
		.step_exc_req, .trap_step_clear, .msg_valid, .msg_source, .msg_target, .mem_valid, .mem_addr,
		.mem_data, .mem_ready, .log_full_irq);
	btr_mem_model mem (.sys_clk, .rstn, .mem_valid, .mem_addr, .mem_data, .slow, .mem_ready);
	// clock at 200 MHz
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// collect messages and pulses; the core drops its trap flag on request
	always @(posedge sys_clk) begin
		if (msg_valid === 1'b1) msgq.push_back({msg_target, msg_source});
		if (step_exc_req === 1'b1) n_step++;
		if (log_full_irq === 1'b1) n_irq++;
		if (trap_step_clear === 1'b1) begin
			n_clr++;
			trap_single_step <= 1'b0;
		end
	end
	function automatic logic [63:0] brec(input int n);
		return {32'h2000_0000 + n[31:0], 32'h1000_0000 + n[31:0]};
	endfunction
	function automatic logic [63:0] xrec(input int n);
		return {32'h4000_0000 + n[31:0], 32'h3000_0000 + n[31:0]};
	endfunction
	task chk(input logic [63:0] s, input logic [63:0] x);
		n_compared++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// one apb transfer; read data and error land in r and e
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd_entry(input int i);
		apb(1'b0, OFS_STACK_BASE + 8'(i * 8), 32'h0);
		rec[31:0] = r;
		apb(1'b0, OFS_STACK_BASE + 8'(i * 8 + 4), 32'h0);
		rec[63:32] = r;
	endtask
	// one core transfer, then wait until the block is idle again
	task xfer(input logic b, input logic x, input logic f, input int n);
		@(posedge sys_clk);
		xfer_valid <= 1'b1;
		xfer_branch <= b;
		xfer_excint <= x;
		excint_fault <= f;
		{branch_to, branch_from} <= brec(n);
		{excint_to, excint_from} <= xrec(n);
		do @(posedge sys_clk); while (xfer_ready !== 1'b1);
		xfer_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		while (xfer_ready !== 1'b1 || mem_valid !== 1'b0) @(posedge sys_clk);
		@(posedge sys_clk); // let the collector take the last pulse first
	endtask
	task t_regs;
		apb(1'b0, OFS_DEBUG_CTL, 32'h0);
		chk(r, 64'(CTL_RESET));
		apb(1'b0, OFS_FEATURE_ID, 32'h0);
		chk(r[FEATURE_DS_BIT], 1'b1);
		apb(1'b0, OFS_MISC_FEAT, 32'h0);
		chk(r[TRACE_ABSENT_BIT], 1'b0);
		apb(1'b1, OFS_DEBUG_CTL, 32'h1F);
		apb(1'b0, OFS_DEBUG_CTL, 32'h0);
		chk(r, 32'h1F);
		apb(1'b0, 8'hFC, 32'h0);
		chk({e, r}, {1'b1, 32'h0});
	endtask
	task t_stack;
		apb(1'b1, OFS_DEBUG_CTL, 32'h01);
		for (int n = 1; n <= 5; n++) xfer(1'b1, 1'b0, 1'b0, n);
		apb(1'b0, OFS_STACK_TOP, 32'h0);
		chk(r, 32'h1);
		for (int i = 0; i < 4; i++) begin
			rd_entry(i);
			chk(rec, brec(i == 0 ? 4 : (i == 1 ? 5 : i)));
		end
		@(posedge sys_clk);
		debug_exc <= 1'b1;
		@(posedge sys_clk);
		debug_exc <= 1'b0;
		xfer(1'b1, 1'b0, 1'b0, 9);
		apb(1'b0, OFS_DEBUG_CTL, 32'h0);
		chk(r[CTL_RECORD_EN], 1'b0);
		apb(1'b0, OFS_STACK_TOP, 32'h0);
		chk(r, 32'h1);
		rd_entry(1);
		chk(rec, brec(5));
	endtask
	task t_trap;
		apb(1'b1, OFS_DEBUG_CTL, 32'h01);
		xfer(1'b1, 1'b1, 1'b0, 6);
		rd_entry(2);
		chk(rec, brec(6));
		rd_entry(3);
		chk(rec, xrec(6));
		apb(1'b0, OFS_LER_TARGET, 32'h0);
		chk(r, brec(6) >> 32);
		xfer(1'b1, 1'b1, 1'b1, 7);
		apb(1'b0, OFS_STACK_TOP, 32'h0);
		chk(r, 32'h0);
		rd_entry(0);
		chk(rec, xrec(7));
		apb(1'b0, OFS_LER_SOURCE, 32'h0);
		chk(r, xrec(6) & 64'hFFFF_FFFF);
	endtask
	task t_msg;
		msgq.delete();
		apb(1'b1, OFS_DEBUG_CTL, 32'h05);
		xfer(1'b1, 1'b1, 1'b0, 8);
		chk(msgq.size(), 2);
		chk(msgq[0], brec(8));
		chk(msgq[1], xrec(8));
		apb(1'b0, OFS_STACK_TOP, 32'h0);
		chk(r, 32'h2);
		apb(1'b1, OFS_DEBUG_CTL, 32'h19);
		xfer(1'b1, 1'b0, 1'b0, 9);
		chk(msgq.size() + mem.words.num(), 2);
	endtask
	task t_step;
		apb(1'b1, OFS_DEBUG_CTL, 32'h03);
		trap_single_step <= 1'b1;
		xfer(1'b0, 1'b1, 1'b0, 10);
		chk({n_step, n_clr}, {32'd1, 32'd1});
		apb(1'b0, OFS_DEBUG_CTL, 32'h0);
		chk({trap_single_step, r[1:0]}, 3'b000);
	endtask
	task t_mem;
		apb(1'b1, OFS_AREA_PTR, 32'h100);
		apb(1'b0, OFS_AREA_PTR, 32'h0);
		chk(r, 32'h100);
		apb(1'b1, OFS_BUF_BASE, 32'h0);
		apb(1'b1, OFS_BUF_INDEX, 32'h0);
		apb(1'b1, OFS_BUF_MAX, 32'h10);
		apb(1'b1, OFS_BUF_THRESH, 32'h10);
		msgq.delete();
		apb(1'b1, OFS_DEBUG_CTL, 32'h0C);
		for (int n = 11; n <= 13; n++) begin
			slow <= n[0];
			xfer(1'b1, 1'b0, 1'b0, n);
		end
		chk(mem.words[0], brec(13));
		chk(mem.words[8], brec(12));
		chk(mem.words[32'h104], 64'h8);
		chk({msgq.size(), n_irq}, 64'h0);
		apb(1'b1, OFS_BUF_INDEX, 32'h0);
		apb(1'b1, OFS_BUF_MAX, 32'h20);
		apb(1'b1, OFS_DEBUG_CTL, 32'h1C);
		for (int n = 14; n <= 16; n++) xfer(1'b1, 1'b0, 1'b0, n);
		chk(n_irq, 1);
		chk(mem.words[16], brec(16));
		apb(1'b0, OFS_BUF_INDEX, 32'h0);
		chk(r, 32'h18);
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// reset for five cycles, then the scenarios
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, xfer_valid, xfer_branch, xfer_excint, excint_fault} = '0;
		{debug_exc, trap_single_step, slow, paddr, pwdata} = '0;
		{branch_from, branch_to, excint_from, excint_to} = '0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs;
		t_stack;
		t_trap;
		t_msg;
		t_step;
		t_mem;
		final_report;
	end
	// watchdog
	initial begin
		#20000;
		error_cnt++;
		final_report;
	end
endmodule
`default_nettype wire
